// file: alu_and_branch_execute.sv
`timescale 1ns/1ps
// Purpose: execute stage for arithmetic, logic and flow-control operations
// Assumes: decoder supplies operands, status byte, pc, pointer and stack top
// Notes:   one request at a time, results and strobes appear with o_done
// Functional notes
// - Register add, with or without carry, stores the sum and sets Z C N V H in one cycle.
// - Word add of a constant to a pair updates Z C N V S in two cycles.
// - Subtracting a register or constant stores the difference, Z C N V H, one cycle.
// - Register borrow subtract removes source and carry, Z C N V H, one cycle.
// - Constant borrow subtract removes constant and carry, Z C N V H, one cycle.
// - Word subtract of a constant from a pair updates Z C N V S over two cycles.
// - AND and OR with register or constant, and exclusive OR with register, change only Z N V S, one cycle.
// - Set bits ORs a constant mask into the register in one cycle, changing only Z N V S.
// - Clear bits ANDs with the inverted mask in one cycle, changing only Z N V S.
// - Test ANDs a register with itself, keeps it, and updates Z N V S in one cycle.
// - Pointer jump loads pc from the pointer pair, no flags, in two cycles.
// - Pointer call pushes the return address, loads pc from the pointer, three cycles.
// - Skip if equal keeps flags, on a match adds 2 or 3 to pc, 1, 2 or 3 cycles.
module alu_and_branch_execute
(
	input  wire logic            i_mclk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_valid,
	input  wire exec_pkg::op_e   i_op,
	input  wire logic [7:0]      i_rd_val,
	input  wire logic [7:0]      i_rr_val,
	input  wire logic [7:0]      i_imm,
	input  wire logic [15:0]     i_pair_val,
	input  wire logic [15:0]     i_ptr,
	input  wire logic [15:0]     i_pc,
	input  wire logic [11:0]     i_offset,
	input  wire logic            i_next_long,
	input  wire logic [15:0]     i_stack_pc,
	input  wire logic [7:0]      i_sreg,
	output logic                 o_ready,
	output logic                 o_done,
	output logic [7:0]           o_result,
	output logic                 o_result_wr,
	output logic [15:0]          o_word,
	output logic                 o_word_wr,
	output logic [7:0]           o_sreg,
	output logic                 o_sreg_wr,
	output logic [15:0]          o_pc,
	output logic                 o_pc_wr,
	output logic [15:0]          o_push_data,
	output logic                 o_push,
	output logic                 o_pop
);
	import exec_pkg::*;

	adder_if add_bus ();

	state_e      state_reg,   state_next;
	logic [2:0]  cnt_reg,     cnt_next;
	logic        done_reg,    done_next;
	logic [7:0]  res_reg,     res_next;
	logic        res_en_reg,  res_en_next;
	logic [15:0] word_reg,    word_next;
	logic        word_en_reg, word_en_next;
	logic [7:0]  sreg_reg,    sreg_next;
	logic        sreg_en_reg, sreg_en_next;
	logic [15:0] pc_reg,      pc_next;
	logic        push_en_reg, push_en_next;
	logic [15:0] push_reg,    push_next;
	logic        pop_en_reg,  pop_en_next;
	logic [16:0] wsum;
	logic [7:0]  lres;
	logic        take;

	// =====================================================
	// flag update shared by all logic operations: V cleared, N Z S follow
	function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r);
		logic [7:0] f;
		f         = s;
		f[FLAG_V] = 1'b0;
		f[FLAG_N] = r[7];
		f[FLAG_Z] = (r == BYTE_ZERO);
		f[FLAG_S] = r[7];
		return f;
	endfunction

	// arithmetic flags from adder outputs
	function automatic logic [7:0] arith_flags(input logic [7:0] s, input logic [7:0] r,
	                                           input logic c, input logic h, input logic v,
	                                           input logic keep_z);
		logic [7:0] f;
		f         = s;
		f[FLAG_C] = c;
		f[FLAG_H] = h;
		f[FLAG_V] = v;
		f[FLAG_N] = r[7];
		f[FLAG_S] = r[7] ^ v;
		f[FLAG_Z] = (r == BYTE_ZERO) & (~keep_z | s[FLAG_Z]);
		return f;
	endfunction

	byte_adder u_adder
	(
		.port_a (add_bus.unit)
	);

	// =====================================================
	// adder operand steering
	always_comb
	begin
		add_bus.a   = i_rd_val;
		add_bus.b   = i_rr_val;
		add_bus.cin = 1'b0;
		add_bus.sub = 1'b0;
		unique case (i_op)
			OP_ADD_CARRY:
				add_bus.cin = i_sreg[FLAG_C];
			OP_SUBTRACT:
				add_bus.sub = 1'b1;
			OP_SUBTRACT_IMMEDIATE:
			begin
				add_bus.b   = i_imm;
				add_bus.sub = 1'b1;
			end
			OP_SUBTRACT_BORROW:
			begin
				add_bus.cin = i_sreg[FLAG_C];
				add_bus.sub = 1'b1;
			end
			OP_SUBTRACT_BORROW_IMMEDIATE:
			begin
				add_bus.b   = i_imm;
				add_bus.cin = i_sreg[FLAG_C];
				add_bus.sub = 1'b1;
			end
			OP_SIGN_FLIP:
			begin
				add_bus.a   = BYTE_ZERO;
				add_bus.b   = i_rd_val;
				add_bus.sub = 1'b1;
			end
			default:
				add_bus.sub = 1'b0;
		endcase
	end

	// word add or subtract of a 6-bit constant
	always_comb
	begin
		if (i_op == OP_WORD_SUBTRACT_IMMEDIATE)
			wsum = {1'b0, i_pair_val} - {11'h000, i_imm[5:0]};
		else
			wsum = {1'b0, i_pair_val} + {11'h000, i_imm[5:0]};
	end

	// bitwise operation result
	always_comb
	begin
		unique case (i_op)
			OP_AND:            lres = i_rd_val & i_rr_val;
			OP_AND_IMMEDIATE:  lres = i_rd_val & i_imm;
			OP_OR:             lres = i_rd_val | i_rr_val;
			OP_OR_IMMEDIATE:   lres = i_rd_val | i_imm;
			OP_SET_BITS:       lres = i_rd_val | i_imm;
			OP_EXCLUSIVE_OR:   lres = i_rd_val ^ i_rr_val;
			OP_CLEAR_BITS:     lres = i_rd_val & (BYTE_ONES ^ i_imm);
			OP_BITWISE_INVERT: lres = BYTE_ONES ^ i_rd_val;
			default:           lres = i_rd_val & i_rd_val;
		endcase
	end

	assign take = i_valid & (state_reg == ST_IDLE);

	// =====================================================
	// sequencer: capture results on take, release them after the cycle count
	always_comb
	begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		done_next    = 1'b0;
		res_next     = res_reg;
		res_en_next  = res_en_reg;
		word_next    = word_reg;
		word_en_next = word_en_reg;
		sreg_next    = sreg_reg;
		sreg_en_next = sreg_en_reg;
		pc_next      = pc_reg;
		push_en_next = push_en_reg;
		push_next    = push_reg;
		pop_en_next  = pop_en_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (take)
				begin
					res_en_next  = 1'b0;
					word_en_next = 1'b0;
					sreg_en_next = 1'b0;
					push_en_next = 1'b0;
					pop_en_next  = 1'b0;
					sreg_next    = i_sreg;
					pc_next      = i_pc + PC_STEP_1;
					cnt_next     = {1'b0, CYC_ONE};
					unique case (i_op)
						OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUBTRACT_IMMEDIATE, OP_SIGN_FLIP:
						begin
							res_next     = add_bus.res;
							res_en_next  = 1'b1;
							sreg_en_next = 1'b1;
							sreg_next    = arith_flags(i_sreg, add_bus.res,
							                           (i_op == OP_SIGN_FLIP) ?
							                           (add_bus.res != BYTE_ZERO) : add_bus.cout,
							                           add_bus.half,
							                           (i_op == OP_SIGN_FLIP) ?
							                           (add_bus.res == NEG_OVF) : add_bus.ovf, 1'b0);
						end
						OP_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_IMMEDIATE:
						begin
							res_next     = add_bus.res;
							res_en_next  = 1'b1;
							sreg_en_next = 1'b1;
							sreg_next    = arith_flags(i_sreg, add_bus.res, add_bus.cout,
							                           add_bus.half, add_bus.ovf, 1'b1);
						end
						OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE:
						begin
							word_next         = wsum[15:0];
							word_en_next      = 1'b1;
							sreg_en_next      = 1'b1;
							sreg_next[FLAG_Z] = (wsum[15:0] == WORD_ZERO);
							sreg_next[FLAG_N] = wsum[15];
							if (i_op == OP_WORD_ADD_IMMEDIATE)
							begin
								sreg_next[FLAG_V] = ~i_pair_val[15] & wsum[15];
								sreg_next[FLAG_C] = ~wsum[15] & i_pair_val[15];
								sreg_next[FLAG_S] = wsum[15] ^ (~i_pair_val[15] & wsum[15]);
							end
							else
							begin
								sreg_next[FLAG_V] = i_pair_val[15] & ~wsum[15];
								sreg_next[FLAG_C] = wsum[15] & ~i_pair_val[15];
								sreg_next[FLAG_S] = wsum[15] ^ (i_pair_val[15] & ~wsum[15]);
							end
							cnt_next = {1'b0, CYC_TWO};
						end
						OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR,
						OP_SET_BITS, OP_CLEAR_BITS, OP_ZERO_MINUS_TEST:
						begin
							res_next     = lres;
							res_en_next  = (i_op != OP_ZERO_MINUS_TEST);
							sreg_en_next = 1'b1;
							sreg_next    = logic_flags(i_sreg, lres);
						end
						OP_BITWISE_INVERT:
						begin
							res_next          = lres;
							res_en_next       = 1'b1;
							sreg_en_next      = 1'b1;
							sreg_next         = logic_flags(i_sreg, lres);
							sreg_next[FLAG_C] = 1'b1;
						end
						OP_SET_ALL_ONES:
						begin
							res_next    = BYTE_ONES;
							res_en_next = 1'b1;
						end
						OP_RELATIVE_JUMP, OP_RELATIVE_CALL:
						begin
							pc_next      = i_pc + {{4{i_offset[11]}}, i_offset} + PC_STEP_1;
							push_next    = i_pc + PC_STEP_1;
							push_en_next = (i_op == OP_RELATIVE_CALL);
							cnt_next     = (i_op == OP_RELATIVE_CALL) ? {1'b0, CYC_THREE}
							                                          : {1'b0, CYC_TWO};
						end
						OP_POINTER_JUMP, OP_POINTER_CALL:
						begin
							pc_next      = i_ptr;
							push_next    = i_pc + PC_STEP_1;
							push_en_next = (i_op == OP_POINTER_CALL);
							cnt_next     = (i_op == OP_POINTER_CALL) ? {1'b0, CYC_THREE}
							                                         : {1'b0, CYC_TWO};
						end
						OP_CALL_EXIT, OP_INTERRUPT_EXIT:
						begin
							pc_next           = i_stack_pc;
							pop_en_next       = 1'b1;
							sreg_en_next      = (i_op == OP_INTERRUPT_EXIT);
							sreg_next[FLAG_I] = 1'b1;
							cnt_next          = CYC_FOUR;
						end
						OP_SKIP_IF_EQUAL:
						begin
							if (i_rd_val == i_rr_val)
							begin
								pc_next  = i_pc + (i_next_long ? PC_STEP_3 : PC_STEP_2);
								cnt_next = i_next_long ? {1'b0, CYC_THREE} : {1'b0, CYC_TWO};
							end
						end
						default:
							cnt_next = {1'b0, CYC_ONE};
					endcase
					if (cnt_next == {1'b0, CYC_ONE})
						done_next = 1'b1;
					else
						state_next = ST_BUSY;
					cnt_next = cnt_next - 3'h1;
				end
			end
			ST_BUSY:
			begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h1)
				begin
					done_next  = 1'b1;
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			state_reg   <= ST_IDLE;
			cnt_reg     <= 3'h0;
			done_reg    <= 1'b0;
			res_reg     <= BYTE_ZERO;
			res_en_reg  <= 1'b0;
			word_reg    <= WORD_ZERO;
			word_en_reg <= 1'b0;
			sreg_reg    <= BYTE_ZERO;
			sreg_en_reg <= 1'b0;
			pc_reg      <= WORD_ZERO;
			push_en_reg <= 1'b0;
			push_reg    <= WORD_ZERO;
			pop_en_reg  <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			done_reg    <= done_next;
			res_reg     <= res_next;
			res_en_reg  <= res_en_next;
			word_reg    <= word_next;
			word_en_reg <= word_en_next;
			sreg_reg    <= sreg_next;
			sreg_en_reg <= sreg_en_next;
			pc_reg      <= pc_next;
			push_en_reg <= push_en_next;
			push_reg    <= push_next;
			pop_en_reg  <= pop_en_next;
		end
	end

	// =====================================================
	// outputs: data from flops, strobes gated by done
	assign o_ready     = (state_reg == ST_IDLE);
	assign o_done      = done_reg;
	assign o_result    = res_reg;
	assign o_result_wr = done_reg & res_en_reg;
	assign o_word      = word_reg;
	assign o_word_wr   = done_reg & word_en_reg;
	assign o_sreg      = sreg_reg;
	assign o_sreg_wr   = done_reg & sreg_en_reg;
	assign o_pc        = pc_reg;
	assign o_pc_wr     = done_reg;
	assign o_push_data = push_reg;
	assign o_push      = done_reg & push_en_reg;
	assign o_pop       = done_reg & pop_en_reg;
endmodule

// file: exec_pkg.sv
// Purpose: shared constants and types for the execute block
// Assumes: 8-bit core, 16-bit program counter counted in words
// Notes:   status byte layout is I T H S V N Z C, bit 7 down to bit 0
package exec_pkg;

	// =====================================================
	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// =====================================================
	// cycle counts per instruction class
	localparam logic [1:0] CYC_ONE   = 2'h1;
	localparam logic [1:0] CYC_TWO   = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [2:0] CYC_FOUR  = 3'h4;

	// =====================================================
	// reset values and fixed operands
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  BYTE_ONES = 8'hff;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] PC_STEP_1 = 16'h0001;
	localparam logic [15:0] PC_STEP_2 = 16'h0002;
	localparam logic [15:0] PC_STEP_3 = 16'h0003;
	localparam logic [7:0]  NEG_OVF   = 8'h80;

	// =====================================================
	// operation codes presented by the decoder
	typedef enum logic [4:0] {
		OP_ADD                       = 5'h00,
		OP_ADD_CARRY                 = 5'h01,
		OP_WORD_ADD_IMMEDIATE        = 5'h02,
		OP_SUBTRACT                  = 5'h03,
		OP_SUBTRACT_IMMEDIATE        = 5'h04,
		OP_SUBTRACT_BORROW           = 5'h05,
		OP_SUBTRACT_BORROW_IMMEDIATE = 5'h06,
		OP_WORD_SUBTRACT_IMMEDIATE   = 5'h07,
		OP_AND                       = 5'h08,
		OP_AND_IMMEDIATE             = 5'h09,
		OP_OR                        = 5'h0a,
		OP_OR_IMMEDIATE              = 5'h0b,
		OP_EXCLUSIVE_OR              = 5'h0c,
		OP_BITWISE_INVERT            = 5'h0d,
		OP_SIGN_FLIP                 = 5'h0e,
		OP_SET_BITS                  = 5'h0f,
		OP_CLEAR_BITS                = 5'h10,
		OP_ZERO_MINUS_TEST           = 5'h11,
		OP_SET_ALL_ONES              = 5'h12,
		OP_RELATIVE_JUMP             = 5'h13,
		OP_POINTER_JUMP              = 5'h14,
		OP_RELATIVE_CALL             = 5'h15,
		OP_POINTER_CALL              = 5'h16,
		OP_CALL_EXIT                 = 5'h17,
		OP_INTERRUPT_EXIT            = 5'h18,
		OP_SKIP_IF_EQUAL             = 5'h19
	} op_e;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} state_e;

endpackage

// file: adder_if.sv
`timescale 1ns/1ps
// Purpose: operand and result bundle between sequencer and byte adder
// Assumes: purely combinational adder behind it
// Notes:   sub selects a - b - cin, otherwise a + b + cin
interface adder_if;
	logic [7:0] a;
	logic [7:0] b;
	logic       cin;
	logic       sub;
	logic [7:0] res;
	logic       cout;
	logic       half;
	logic       ovf;

	modport core (output a, b, cin, sub, input res, cout, half, ovf);
	modport unit (input a, b, cin, sub, output res, cout, half, ovf);
endinterface

// file: byte_adder.sv
`timescale 1ns/1ps
// Purpose: 8-bit add/subtract with carry, half carry and overflow
// Assumes: borrow is reported on cout for subtraction
// Notes:   combinational, results are registered by the caller
module byte_adder
(
	adder_if.unit port_a
);
	import exec_pkg::*;

	logic [8:0] wide;
	logic       a3;
	logic       b3;
	logic       r3;
	logic       a7;
	logic       b7;
	logic       r7;

	// =====================================================
	// sum or difference with carry chain
	always_comb
	begin
		if (port_a.sub)
			wide = {1'b0, port_a.a} - {1'b0, port_a.b} - {8'h00, port_a.cin};
		else
			wide = {1'b0, port_a.a} + {1'b0, port_a.b} + {8'h00, port_a.cin};
	end

	assign a3 = port_a.a[3];
	assign b3 = port_a.b[3];
	assign r3 = wide[3];
	assign a7 = port_a.a[7];
	assign b7 = port_a.b[7];
	assign r7 = wide[7];

	// flag terms; subtraction uses borrow forms
	assign port_a.res  = wide[7:0];
	assign port_a.cout = wide[8];
	assign port_a.half = port_a.sub ? ((~a3 & b3) | (b3 & r3) | (r3 & ~a3))
	                                : ((a3 & b3) | (b3 & ~r3) | (~r3 & a3));
	assign port_a.ovf  = port_a.sub ? ((a7 & ~b7 & ~r7) | (~a7 & b7 & r7))
	                                : ((a7 & b7 & ~r7) | (~a7 & ~b7 & r7));
endmodule

// file: alu_exec_assertions.sv
// Purpose: port-level timing and value checks for the execute block
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to every execute block by the bind at the foot
`timescale 1ns/1ps
module alu_exec_checker
(
	input  wire logic          i_mclk,
	input  wire logic          i_sys_rst,
	input  wire logic          i_valid,
	input  wire exec_pkg::op_e i_op,
	input  wire logic [7:0]    i_rd_val,
	input  wire logic [7:0]    i_rr_val,
	input  wire logic [15:0]   i_ptr,
	input  wire logic [15:0]   i_pc,
	input  wire logic [7:0]    i_sreg,
	input  wire logic          o_ready,
	input  wire logic          o_done,
	input  wire logic          o_result_wr,
	input  wire logic          o_word_wr,
	input  wire logic [7:0]    o_sreg,
	input  wire logic          o_sreg_wr,
	input  wire logic [15:0]   o_pc,
	input  wire logic [15:0]   o_push_data,
	input  wire logic          o_push,
	input  wire logic          o_pop
);
	import exec_pkg::*;
	logic tk;

	// =====================================================
	// request taken at this edge
	assign tk = i_valid && o_ready;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	// =====================================================
	// add one cycle
	a_add_one_cycle: assert property (tk && i_op inside {OP_ADD, OP_ADD_CARRY}
		|=> o_done && o_result_wr && o_sreg_wr) else $error("add late");
	a_word_two: assert property (tk && i_op inside {OP_WORD_ADD_IMMEDIATE,
		OP_WORD_SUBTRACT_IMMEDIATE} |=> (!o_done) ##1 (o_done && o_word_wr)) else $error("word late");
	a_borrow_zero: assert property (tk && !i_sreg[FLAG_Z] && i_op inside
		{OP_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_IMMEDIATE} |=> o_done && !o_sreg[FLAG_Z])
		else $error("borrow zero flag");
	a_logic_flags: assert property (tk && i_op inside {OP_AND, OP_OR,
		OP_EXCLUSIVE_OR, OP_SET_BITS, OP_CLEAR_BITS} |=> o_sreg_wr && !o_sreg[FLAG_V]
		&& o_sreg[FLAG_C] == $past(i_sreg[FLAG_C])) else $error("logic flags");
	a_test_no_write: assert property (tk && i_op == OP_ZERO_MINUS_TEST
		|=> o_done && !o_result_wr && o_sreg_wr) else $error("test wrote result");
	a_ptr_jump: assert property (tk && i_op == OP_POINTER_JUMP
		|=> (!o_done) ##1 (o_done && o_pc == $past(i_ptr, 2))) else $error("pointer jump");
	a_ptr_call: assert property (tk && i_op == OP_POINTER_CALL
		|=> (!o_done) [*2] ##1 (o_push && o_push_data == $past(i_pc, 3) + 16'h0001))
		else $error("pointer call");
	a_skip_unequal: assert property (tk && i_op == OP_SKIP_IF_EQUAL && i_rd_val != i_rr_val
		|=> o_done && !o_sreg_wr && o_pc == $past(i_pc) + 16'h0001) else $error("skip unequal");
	a_return_four: assert property (tk && i_op inside {OP_CALL_EXIT, OP_INTERRUPT_EXIT}
		|=> (!o_done) [*3] ##1 (o_done && o_pop)) else $error("return timing");
endmodule

bind alu_and_branch_execute alu_exec_checker u_alu_exec_checker (.i_mclk, .i_sys_rst, .i_valid,
	.i_op, .i_rd_val, .i_rr_val, .i_ptr, .i_pc, .i_sreg, .o_ready, .o_done, .o_result_wr,
	.o_word_wr, .o_sreg, .o_sreg_wr, .o_pc, .o_push_data, .o_push, .o_pop);

// file: tb.sv
// Purpose: self-checking bench for the execute block
// Assumes: request taken while ready, results strobed with done
// Notes:   a bench model predicts every completion
`timescale 1ns/1ps
module tb;
	import exec_pkg::*;
	`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
		$display("wrong value %s expected %h seen %h", n, e, g); end end
	op_e         i_op;
	logic        i_mclk, i_sys_rst, i_valid, i_next_long, o_ready, o_done, o_result_wr;
	logic        o_word_wr, o_sreg_wr, o_pc_wr, o_push, o_pop, e_rwr, e_swr, e_wwr, e_push, e_pop;
	logic [7:0]  i_rd_val, i_rr_val, i_imm, i_sreg, o_result, o_sreg, e_res, e_sreg;
	logic [11:0] i_offset;
	logic [15:0] i_pair_val, i_ptr, i_pc, i_stack_pc, o_word, o_pc, o_push_data, e_word, e_pc;
	int          e_cyc, err_total, n_checks, seed, k;
	int          exp_q[$];
	logic [7:0]  stb;

	alu_and_branch_execute u_alu_and_branch_execute (.i_mclk, .i_sys_rst, .i_valid, .i_op,
		.i_rd_val, .i_rr_val, .i_imm, .i_pair_val, .i_ptr, .i_pc, .i_offset, .i_next_long,
		.i_stack_pc, .i_sreg, .o_ready, .o_done, .o_result, .o_result_wr, .o_word, .o_word_wr,
		.o_sreg, .o_sreg_wr, .o_pc, .o_pc_wr, .o_push_data, .o_push, .o_pop);

	// handshake and strobe outputs gathered for one compare
	assign stb = {o_ready, o_done, o_pc_wr, o_result_wr, o_sreg_wr, o_word_wr, o_push, o_pop};

	// 125 MHz clock
	initial
	begin
		i_mclk = 0;
		forever #4 i_mclk = ~i_mclk;
	end

	// =====================================================
	// model: byte result with n, z, s
	task automatic res(input int r, kz);
		e_res = r[7:0];
		e_rwr = 1;
		e_sreg[FLAG_N] = r[7];
		e_sreg[FLAG_Z] = (r[7:0] == 0) && (!kz || i_sreg[FLAG_Z]);
		e_sreg[FLAG_S] = r[7] ^ e_sreg[FLAG_V];
	endtask

	// logic ops clear overflow
	task automatic lop(input int r);
		e_sreg[FLAG_V] = 0;
		res(r, 0);
	endtask

	// byte add or subtract with carry in
	task automatic arith(input int a, b, ci, sb, kz);
		int r;
		int h;
		r = sb ? a - b - ci : a + b + ci;
		h = sb ? (a & 15) - (b & 15) - ci : (a & 15) + (b & 15) + ci;
		e_sreg[FLAG_C] = r[8];
		e_sreg[FLAG_H] = h[4];
		e_sreg[FLAG_V] = ((a[7] ^ b[7]) == sb[0]) && (r[7] != a[7]);
		res(r, kz);
	endtask

	// word add or subtract of a six-bit constant
	task automatic word(input int sb);
		int p;
		int r;
		p = i_pair_val;
		r = sb ? p - i_imm[5:0] : p + i_imm[5:0];
		e_word = r[15:0];
		e_wwr = 1;
		e_cyc = 2;
		e_sreg[FLAG_C] = r[16];
		e_sreg[FLAG_V] = sb ? p[15] & !r[15] : !p[15] & r[15];
		e_sreg[FLAG_N] = r[15];
		e_sreg[FLAG_Z] = r[15:0] == 0;
		e_sreg[FLAG_S] = r[15] ^ e_sreg[FLAG_V];
	endtask

	// predicts outputs from the inputs at take
	task automatic model();
		int a;
		int b;
		int c;
		a = i_rd_val;
		b = i_rr_val;
		c = i_sreg[FLAG_C];
		{e_rwr, e_swr, e_wwr, e_push, e_pop} = 5'b01000;
		e_cyc = 1;
		e_sreg = i_sreg;
		e_pc = i_pc + 16'h0001;
		case (i_op)
			OP_ADD: arith(a, b, 0, 0, 0);
			OP_ADD_CARRY: arith(a, b, c, 0, 0);
			OP_SUBTRACT: arith(a, b, 0, 1, 0);
			OP_SUBTRACT_IMMEDIATE: arith(a, i_imm, 0, 1, 0);
			OP_SUBTRACT_BORROW: arith(a, b, c, 1, 1);
			OP_SUBTRACT_BORROW_IMMEDIATE: arith(a, i_imm, c, 1, 1);
			OP_SIGN_FLIP: arith(0, a, 0, 1, 0);
			OP_WORD_ADD_IMMEDIATE: word(0);
			OP_WORD_SUBTRACT_IMMEDIATE: word(1);
			OP_AND: lop(a & b);
			OP_AND_IMMEDIATE: lop(a & i_imm);
			OP_OR: lop(a | b);
			OP_OR_IMMEDIATE, OP_SET_BITS: lop(a | i_imm);
			OP_EXCLUSIVE_OR: lop(a ^ b);
			OP_CLEAR_BITS: lop(a & ~i_imm);
			OP_ZERO_MINUS_TEST: lop(a);
			OP_BITWISE_INVERT: lop(255 - a);
			OP_SET_ALL_ONES: {e_res, e_rwr, e_swr} = {8'hff, 2'b10};
			OP_RELATIVE_JUMP, OP_RELATIVE_CALL: e_pc = i_pc + {{4{i_offset[11]}}, i_offset} + 16'h0001;
			OP_POINTER_JUMP, OP_POINTER_CALL: e_pc = i_ptr;
			OP_CALL_EXIT, OP_INTERRUPT_EXIT: e_pc = i_stack_pc;
			OP_SKIP_IF_EQUAL: e_cyc = (a == b) ? 2 + i_next_long : 1;
			default: ;
		endcase
		if (i_op == OP_ZERO_MINUS_TEST)
			e_rwr = 0;
		if (i_op == OP_BITWISE_INVERT)
			e_sreg[FLAG_C] = 1;
		if (i_op >= OP_RELATIVE_JUMP)
			e_swr = 0;
		if (i_op == OP_INTERRUPT_EXIT)
			{e_swr, e_sreg[FLAG_I]} = 2'b11;
		if (i_op inside {OP_RELATIVE_JUMP, OP_POINTER_JUMP})
			e_cyc = 2;
		e_push = i_op inside {OP_RELATIVE_CALL, OP_POINTER_CALL};
		e_pop = i_op inside {OP_CALL_EXIT, OP_INTERRUPT_EXIT};
		if (e_push)
			e_cyc = 3;
		if (e_pop)
			e_cyc = 4;
		if (i_op == OP_SKIP_IF_EQUAL)
			e_pc = i_pc + 16'(e_cyc);
	endtask

	// =====================================================
	// one request, refused requests while busy, compare at done
	task automatic run(input op_e op, input logic [7:0] rd, rr);
		int cyc;
		int epc;
		i_op = op;
		i_rd_val = rd;
		i_rr_val = rr;
		{i_imm, i_sreg, i_offset, i_next_long} = 29'($random(seed));
		{i_pair_val, i_ptr} = $random(seed);
		{i_pc, i_stack_pc} = $random(seed);
		i_valid = 1;
		model();
		exp_q.push_back(e_pc);
		`CHK("ready", 1'b1, o_ready)
		for (cyc = 1; cyc < 6; cyc++)
		begin
			@(posedge i_mclk);
			#1;
			if (o_done === 1'b1)
				break;
			`CHK("busy ready", 1'b0, o_ready)
			i_rd_val = $random(seed);
		end
		`CHK("cycles", e_cyc, cyc)
		if (cyc > 4)
			complete_run();
		epc = exp_q.pop_front();
		`CHK("pc", epc, o_pc)
		`CHK("strobes", {3'b111, e_rwr, e_swr, e_wwr, e_push, e_pop}, stb)
		if (e_rwr) `CHK("result", e_res, o_result)
		if (e_swr) `CHK("flags", e_sreg, o_sreg)
		if (e_wwr) `CHK("word", e_word, o_word)
		if (e_push) `CHK("return address", i_pc + 16'h0001, o_push_data)
	endtask

	// verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// =====================================================
	// main sequence
	initial
	begin
		seed = 32'h5e415745;
		err_total = 0;
		n_checks = 0;
		i_sys_rst = 1;
		i_valid = 0;
		i_op = OP_ADD;
		{i_rd_val, i_rr_val, i_imm, i_sreg, i_offset, i_next_long} = '0;
		{i_pair_val, i_ptr, i_pc, i_stack_pc} = '0;
		repeat (10) @(posedge i_mclk);
		#1;
		i_sys_rst = 0;
		`CHK("reset state", 40'h80_0000_0000, {stb, o_sreg, o_pc, o_result})
		$display("reset test done");
		for (k = 0; k < 26; k++)
		begin
			run(op_e'(k), 8'hff, 8'h01);
			run(op_e'(k), 8'h80, 8'h80);
		end
		// equal skips with both short and long following instructions
		for (k = 0; k < 8; k++)
			run(OP_SKIP_IF_EQUAL, 8'(k), 8'(k));
		$display("opcode sweep test done");
		for (k = 0; k < 400; k++)
			run(op_e'($unsigned($random(seed)) % 26), 8'($random(seed)), 8'($random(seed)));
		$display("random back to back test done");
		i_valid = 0;
		@(posedge i_mclk);
		#1;
		i_op = OP_POINTER_CALL;
		i_valid = 1;
		@(posedge i_mclk);
		#1;
		i_valid = 0;
		i_sys_rst = 1;
		repeat (2) @(posedge i_mclk);
		#1;
		i_sys_rst = 0;
		`CHK("abort idle", 2'b10, {o_ready, o_done})
		repeat (3) @(posedge i_mclk);
		#1;
		`CHK("no late push", 2'b00, {o_push, o_done})
		run(OP_ADD_CARRY, 8'h0f, 8'h01);
		$display("abort test done");
		complete_run();
	end
endmodule
